// file: hw/sadc_device.sv
// Converter end: sample, serial readout and power-down by frame length
`default_nettype none

// Notes on behaviour
// [R1] Sample and start on select falling edge
// [R2] Serial clock runs conversion and shifting
// [R3] Four zeros then twelve bits, MSB first
// [R4] First zero at select fall, MSB edge four
// [R5] Sixteenth falling edge ends, output released
// [R6] Acquisition starts rising edge after thirteenth
// [R7] Host ends frame, waits quiet time
// [R8] Early select rise skips acquisition, next invalid
// [R9] Select rise aborts conversion, output released
// [R10] Rise between edges two and nine: sleep
// [R11] Sleep entry halts conversion, output released
// [R12] Frame over ten falling edges wakes device
// [R13] Full power one microsecond after wake fall
// [R14] Host waits microsecond after wake frame; code counts it from the wake frame's select fall
// [R15] Serial clock phases at least 0.4
// [R16] Quiet time at least 40 ns
// [R17] First result after reset is invalid
// [R18] Host captures bit on next falling edge
module sadc_device (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic [11:0] analog_input_i,
    output logic             ready_o,
    output logic             power_down_o,
    sadc_link_if.dev         link
);

    logic [4:0]  cnt, next_cnt;
    logic        bit_q, next_bit;
    logic        done, next_done;
    logic        frame_ok, next_frame_ok;
    logic        acq, next_acq;
    logic        rdy_m, rdy_s;
    logic        pd, next_pd;
    logic        valid, next_valid;
    logic [11:0] result;
    logic [11:0] word;
    logic [4:0]  idx;
    logic        cs_m, cs_s, cs_d;
    logic        pd_m, pd_s;
    logic [5:0]  tmr, next_tmr;
    logic        ready, next_ready;

    assign ready_o      = ready;
    assign power_down_o = pd_s;
    assign link.serial_data_out     = bit_q;
    // Released as soon as select rises or the word is over
    assign link.sdo_oe  = ~link.cs_n & ~done;  // [R5] [R9] [R11]

    // ----------------------------------------
    // Sample capture at select fall
    // ----------------------------------------
    always_ff @(negedge link.cs_n or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result <= sadc_pkg::INVALID_CODE;
        end else begin
            result <= valid ? analog_input_i : sadc_pkg::INVALID_CODE;  // [R1] [R8]
        end
    end

    // ----------------------------------------
    // Falling-edge shifter, cleared while deselected
    // ----------------------------------------
    assign word = frame_ok ? result : sadc_pkg::INVALID_CODE;
    assign idx  = sadc_pkg::EDGE_LSB - next_cnt;

    always_comb begin
        next_cnt      = (cnt == sadc_pkg::EDGE_END) ? cnt : cnt + 1'b1;  // [R2]
        next_done     = (next_cnt == sadc_pkg::EDGE_END);                // [R5]
        next_frame_ok = (next_cnt == sadc_pkg::EDGE_CHECK) ? rdy_s : frame_ok;
        next_bit      = 1'b0;                                            // [R3] [R4]
        if (next_cnt >= sadc_pkg::EDGE_MSB && next_cnt <= sadc_pkg::EDGE_LSB) begin
            next_bit = word[idx[3:0]];                                   // [R3] [R4]
        end
    end

    always_ff @(negedge link.sclk or posedge link.cs_n or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt      <= 5'h00;
            bit_q    <= 1'b0;
            done     <= 1'b0;
            frame_ok <= 1'b0;
        end else if (link.cs_n) begin
            // Any rise aborts the frame
            cnt      <= 5'h00;  // [R9]
            bit_q    <= 1'b0;   // [R4]
            done     <= 1'b0;
            frame_ok <= 1'b0;
        end else begin
            cnt      <= next_cnt;
            bit_q    <= next_bit;
            done     <= next_done;
            frame_ok <= next_frame_ok;
        end
    end

    // ----------------------------------------
    // Acquisition start on rising edge
    // ----------------------------------------
    always_comb begin
        next_acq = acq | (cnt >= sadc_pkg::EDGE_ACQ);  // [R6]
    end

    always_ff @(posedge link.sclk or posedge link.cs_n or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acq <= 1'b0;
        end else if (link.cs_n) begin
            acq <= 1'b0;
        end else begin
            acq <= next_acq;
        end
    end

    // ----------------------------------------
    // Readiness into the serial clock domain
    // ----------------------------------------
    always_ff @(negedge link.sclk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdy_m <= 1'b0;
            rdy_s <= 1'b0;
        end else begin
            rdy_m <= ready;
            rdy_s <= rdy_m;
        end
    end

    // ----------------------------------------
    // Frame end: power mode and next validity
    // ----------------------------------------
    always_comb begin
        next_pd = pd;
        if (pd) begin
            if (cnt >= sadc_pkg::EDGE_WAKE) begin
                next_pd = 1'b0;  // [R12]
            end
        end else if (cnt >= sadc_pkg::EDGE_PD_MIN && cnt <= sadc_pkg::EDGE_PD_MAX) begin
            next_pd = 1'b1;      // [R10] [R11]
        end
        next_valid = acq & ~next_pd;  // [R8]
    end

    always_ff @(posedge link.cs_n or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pd    <= 1'b0;
            valid <= 1'b0;  // [R17]
        end else begin
            pd    <= next_pd;
            valid <= next_valid;
        end
    end

    // ----------------------------------------
    // Wake timer on the local clock
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            cs_d <= 1'b1;
            pd_m <= 1'b0;
            pd_s <= 1'b0;
        end else begin
            cs_m <= link.cs_n;
            cs_s <= cs_m;
            cs_d <= cs_s;
            pd_m <= pd;
            pd_s <= pd_m;
        end
    end

    always_comb begin
        next_tmr = (tmr < sadc_pkg::WAKE_CYC) ? tmr + 1'b1 : tmr;
        if (cs_d && !cs_s && !ready) begin
            next_tmr = 6'h00;  // [R13]
        end
        next_ready = (next_tmr >= sadc_pkg::WAKE_CYC) & ~pd_s;  // [R13]
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tmr   <= sadc_pkg::WAKE_CYC;
            ready <= 1'b0;
        end else begin
            tmr   <= next_tmr;
            ready <= next_ready;
        end
    end

endmodule : sadc_device

`default_nettype wire

// file: hw/sadc_fifo.sv
// Result buffer with valid and ready on both sides
`default_nettype none

module sadc_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

endmodule : sadc_fifo

`default_nettype wire

// file: hw/sadc_host.sv
// Host end: frames the link, captures results and buffers them
`default_nettype none

module sadc_host (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        cmd_valid_i,
    input  wire logic [1:0]  cmd_i,
    output logic             cmd_ready_o,
    output logic             res_valid_o,
    output logic [11:0]      res_data_o,
    input  wire logic        res_ready_i,
    sadc_link_if.host        link
);

    sadc_pkg::sadc_state_t state;
    sadc_pkg::sadc_state_t next_state;
    logic        cs_n, next_cs_n;
    logic        sclk, next_sclk;
    logic [1:0]  hc, next_hc;
    logic [4:0]  nf, next_nf;
    logic [4:0]  target, next_target;
    logic [1:0]  cmd_q, next_cmd_q;
    logic [15:0] shift, next_shift;
    logic [5:0]  qt, next_qt;
    logic [5:0]  sf, next_sf;
    logic        wake_pend, next_wake_pend;
    logic        prev_acq, next_prev_acq;
    logic        push, next_push;
    logic        cmd_ready, next_cmd_ready;
    logic        sdo_m, sdo_s;
    logic        fifo_in_ready;

    assign link.cs_n   = cs_n;
    assign link.sclk   = sclk;
    assign cmd_ready_o = cmd_ready;

    // ----------------------------------------
    // Data line synchroniser
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sdo_m <= 1'b0;
            sdo_s <= 1'b0;
        end else begin
            sdo_m <= link.sdo_line;
            sdo_s <= sdo_m;
        end
    end

    // ----------------------------------------
    // Frame sequencer
    // ----------------------------------------
    always_comb begin
        next_state     = state;
        next_cs_n      = cs_n;
        next_sclk      = sclk;
        next_hc        = hc;
        next_nf        = nf;
        next_target    = target;
        next_cmd_q     = cmd_q;
        next_shift     = shift;
        next_qt        = qt;
        next_sf        = (sf < sadc_pkg::WAKE_CYC) ? sf + 1'b1 : sf;
        next_wake_pend = wake_pend;
        next_prev_acq  = prev_acq;
        next_push      = 1'b0;
        case (state)
            sadc_pkg::SADC_ST_IDLE: begin
                if (cmd_valid_i && cmd_ready) begin
                    next_cs_n  = 1'b0;
                    next_sclk  = 1'b1;
                    next_hc    = 2'h0;
                    next_nf    = 5'h00;
                    next_sf    = 6'h00;
                    next_cmd_q = cmd_i;
                    next_state = sadc_pkg::SADC_ST_RUN;
                    case (cmd_i)
                        sadc_pkg::SADC_CMD_SLEEP: next_target = sadc_pkg::EDGE_SLEEP;  // [R10]
                        sadc_pkg::SADC_CMD_WAKE:  next_target = sadc_pkg::EDGE_WAKE;   // [R12] [R14]
                        default:                  next_target = sadc_pkg::EDGE_END;    // [R7] [R8]
                    endcase
                end
            end
            sadc_pkg::SADC_ST_RUN: begin
                if (hc == sadc_pkg::SCLK_HALF_LAST) begin  // [R15]
                    next_hc = 2'h0;
                    if (sclk) begin
                        next_sclk  = 1'b0;
                        next_nf    = nf + 1'b1;
                        next_shift = {shift[14:0], sdo_s};  // [R18]
                    end else if (nf == target) begin
                        next_sclk      = 1'b1;
                        next_cs_n      = 1'b1;
                        next_qt        = 6'h00;
                        next_state     = sadc_pkg::SADC_ST_QUIET;
                        next_wake_pend = (cmd_q == sadc_pkg::SADC_CMD_WAKE);
                        next_prev_acq  = (cmd_q == sadc_pkg::SADC_CMD_CONVERT);
                        // Drop the result of a frame not preceded by acquisition
                        next_push      = (cmd_q == sadc_pkg::SADC_CMD_CONVERT) && prev_acq;  // [R17] [R8]
                    end else begin
                        next_sclk = 1'b1;
                    end
                end else begin
                    next_hc = hc + 1'b1;
                end
            end
            sadc_pkg::SADC_ST_QUIET: begin
                next_qt = (qt < sadc_pkg::QUIET_CYC) ? qt + 1'b1 : qt;
                if (qt >= sadc_pkg::QUIET_CYC - 6'h01 &&
                    (!wake_pend || sf >= sadc_pkg::WAKE_CYC)) begin  // [R16] [R14]
                    next_state = sadc_pkg::SADC_ST_IDLE;
                end
            end
            default: begin
                next_state = sadc_pkg::SADC_ST_IDLE;
            end
        endcase
        next_cmd_ready = (next_state == sadc_pkg::SADC_ST_IDLE) && fifo_in_ready;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state     <= sadc_pkg::SADC_ST_IDLE;
            cs_n      <= 1'b1;
            sclk      <= 1'b1;
            hc        <= 2'h0;
            nf        <= 5'h00;
            target    <= sadc_pkg::EDGE_END;
            cmd_q     <= sadc_pkg::SADC_CMD_CONVERT;
            shift     <= 16'h0000;
            qt        <= 6'h00;
            sf        <= sadc_pkg::WAKE_CYC;
            wake_pend <= 1'b0;
            prev_acq  <= 1'b0;
            push      <= 1'b0;
            cmd_ready <= 1'b0;
        end else begin
            state     <= next_state;
            cs_n      <= next_cs_n;
            sclk      <= next_sclk;
            hc        <= next_hc;
            nf        <= next_nf;
            target    <= next_target;
            cmd_q     <= next_cmd_q;
            shift     <= next_shift;
            qt        <= next_qt;
            sf        <= next_sf;
            wake_pend <= next_wake_pend;
            prev_acq  <= next_prev_acq;
            push      <= next_push;
            cmd_ready <= next_cmd_ready;
        end
    end

    // ----------------------------------------
    // Result buffer
    // ----------------------------------------
    sadc_fifo #(
        .WIDTH (sadc_pkg::RES_BITS),
        .DEPTH (sadc_pkg::FIFO_DEPTH)
    ) u_sadc_fifo (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (shift[11:0]),
        .out_valid_o (res_valid_o),
        .out_ready_i (res_ready_i),
        .out_data_o  (res_data_o)
    );

endmodule : sadc_host

`default_nettype wire

// file: hw/sadc_link_if.sv
// Link between host controller and converter: select, serial clock, data line
`default_nettype none

interface sadc_link_if;

    logic cs_n;
    logic sclk;
    logic serial_data_out;
    logic sdo_oe;
    wire  sdo_line;

    // Released line shows the inverse of serial_data_out
    assign sdo_line = sdo_oe ? serial_data_out : ~serial_data_out;

    modport dev (
        input  cs_n,
        input  sclk,
        output serial_data_out,
        output sdo_oe
    );

    modport host (
        output cs_n,
        output sclk,
        input  sdo_line
    );

endinterface : sadc_link_if

`default_nettype wire

// file: hw/sadc_pkg.sv
// Shared constants and types for the serial converter link
`default_nettype none

package sadc_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int          CLK_PERIOD_NS  = 20;
    localparam int          QUIET_NS       = 40;
    localparam int          WAKE_NS        = 1000;
    localparam logic [5:0]  QUIET_CYC      = 6'((QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [5:0]  WAKE_CYC       = 6'((WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int          SCLK_HALF_CYC  = 4;
    localparam logic [1:0]  SCLK_HALF_LAST = 2'(SCLK_HALF_CYC - 1);

    // ----------------------------------------
    // Frame layout, counted in falling edges
    // ----------------------------------------
    localparam int          WORD_BITS      = 16;
    localparam int          RES_BITS       = 12;
    localparam logic [4:0]  EDGE_PD_MIN    = 5'h02;
    localparam logic [4:0]  EDGE_CHECK     = 5'h02;
    localparam logic [4:0]  EDGE_MSB       = 5'h04;
    localparam logic [4:0]  EDGE_PD_MAX    = 5'h09;
    localparam logic [4:0]  EDGE_WAKE      = 5'h0b;
    localparam logic [4:0]  EDGE_ACQ       = 5'h0d;
    localparam logic [4:0]  EDGE_LSB       = 5'h0f;
    localparam logic [4:0]  EDGE_END       = 5'h10;
    localparam logic [4:0]  EDGE_SLEEP     = 5'h04;
    localparam logic [11:0] INVALID_CODE   = 12'h000;

    // ----------------------------------------
    // Buffering
    // ----------------------------------------
    localparam int          FIFO_DEPTH     = 8;

    // ----------------------------------------
    // Commands and host states
    // ----------------------------------------
    typedef enum logic [1:0] {
        SADC_CMD_CONVERT = 2'b00,
        SADC_CMD_SLEEP   = 2'b01,
        SADC_CMD_WAKE    = 2'b10
    } sadc_cmd_t;

    typedef enum logic [1:0] {
        SADC_ST_IDLE  = 2'b00,
        SADC_ST_RUN   = 2'b01,
        SADC_ST_QUIET = 2'b10
    } sadc_state_t;

endpackage : sadc_pkg

`default_nettype wire

// file: test/sadc_link_chk.sv
// Checker for select, serial clock and data line timing on the link
`default_nettype none

module sadc_link_chk (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic serial_data_out,
    input wire logic sdo_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    logic       sclk_q;
    logic       fall;
    logic [4:0] cnt;
    logic [4:0] next_cnt;

    // ----------------------------------------
    // Falling edges counted within a frame
    // ----------------------------------------
    always_comb begin
        fall     = sclk_q & ~sclk;
        next_cnt = cs_n ? 5'h00 : cnt + 5'(fall);
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_q <= 1'b1;
            cnt    <= 5'h00;
        end else begin
            sclk_q <= sclk;
            cnt    <= next_cnt;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    property p_select_drives; $fell(cs_n) |-> sdo_oe && !serial_data_out; endproperty
    a_select_drives: assert property (p_select_drives) else $error("line not driven low at select");

    property p_leading_zeros; !cs_n && cnt < 5'h04 && !(fall && cnt == 5'h03) |-> !serial_data_out; endproperty
    a_leading_zeros: assert property (p_leading_zeros) else $error("leading bit not zero");

    property p_release_last; fall && cnt == 5'h0f |-> !sdo_oe; endproperty
    a_release_last: assert property (p_release_last) else $error("line not released at last fall");

    property p_drive_whole; !cs_n && cnt < 5'h0f |-> sdo_oe; endproperty
    a_drive_whole: assert property (p_drive_whole) else $error("line released inside word");

    property p_release_high; cs_n |-> !sdo_oe && !serial_data_out; endproperty
    a_release_high: assert property (p_release_high) else $error("line driven while deselected");

    property p_bit_stable; sdo_oe && $past(sdo_oe) && !fall |-> $stable(serial_data_out); endproperty
    a_bit_stable: assert property (p_bit_stable) else $error("data changed off a falling edge");

    property p_frame_len; $rose(cs_n) |-> cnt == 5'h10 || cnt == 5'h04 || cnt == 5'h0b; endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame ended at wrong count");

    property p_quiet; $rose(cs_n) |=> cs_n; endproperty
    a_quiet: assert property (p_quiet) else $error("select fell too soon");

    property p_sclk_low; $fell(sclk) |-> !sclk [*4]; endproperty
    a_sclk_low: assert property (p_sclk_low) else $error("serial clock low phase short");

    property p_sclk_high; $rose(sclk) && !cs_n |-> sclk [*4]; endproperty
    a_sclk_high: assert property (p_sclk_high) else $error("serial clock high phase short");

endmodule : sadc_link_chk

`default_nettype wire

// file: test/test_serial_adc_conversion_interface.sv
// Testbench: host and converter ends joined over the link
`default_nettype none

module test_serial_adc_conversion_interface;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int LIMIT = 20000;

    logic        clock_i;
    logic        dev_clk;
    logic        rst_n_i;
    logic        cmd_valid_i;
    logic [1:0]  cmd_i;
    logic        cmd_ready_o;
    logic        res_valid_o;
    logic [11:0] res_data_o;
    logic        res_ready_i;
    logic [11:0] analog_input_i;
    logic        ready_o;
    logic        power_down_o;
    int          mismatches;
    int          check_count;
    int          cycles;

    sadc_link_if u_sadc_link_if ();

    sadc_host u_sadc_host (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .cmd_valid_i (cmd_valid_i),
        .cmd_i       (cmd_i),
        .cmd_ready_o (cmd_ready_o),
        .res_valid_o (res_valid_o),
        .res_data_o  (res_data_o),
        .res_ready_i (res_ready_i),
        .link        (u_sadc_link_if.host)
    );

    sadc_device u_sadc_device (
        .clock_i        (dev_clk),
        .rst_n_i        (rst_n_i),
        .analog_input_i (analog_input_i),
        .ready_o        (ready_o),
        .power_down_o   (power_down_o),
        .link           (u_sadc_link_if.dev)
    );

    sadc_link_chk u_sadc_link_chk (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .cs_n    (u_sadc_link_if.cs_n),
        .sclk    (u_sadc_link_if.sclk),
        .serial_data_out     (u_sadc_link_if.serial_data_out),
        .sdo_oe  (u_sadc_link_if.sdo_oe)
    );

    // ----------------------------------------
    // Clocks, timeout
    // ----------------------------------------
    always #10 clock_i = ~clock_i;
    always #11 dev_clk = ~dev_clk;

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            end_sim();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic send_cmd(input logic [1:0] c, input int lim, output bit ok);
        int n;
        n = 0;
        ok = 1'b0;
        @(posedge clock_i);
        #1 cmd_i = c;
        cmd_valid_i = 1'b1;
        while (!ok && n < lim) begin
            ok = (cmd_ready_o === 1'b1);
            @(posedge clock_i);
            n++;
        end
        #1 cmd_valid_i = 1'b0;
    endtask : send_cmd

    task automatic pop(output logic [11:0] d);
        int n;
        @(posedge clock_i);
        #1 n = 0;
        while (res_valid_o !== 1'b1 && n < 400) begin
            @(posedge clock_i);
            #1 n++;
        end
        d = (n < 400) ? res_data_o : 12'hxxx;
        res_ready_i = 1'b1;
        @(posedge clock_i);
        #1 res_ready_i = 1'b0;
    endtask : pop

    task automatic conv(input logic [11:0] v);
        bit          ok;
        logic [11:0] d;
        analog_input_i = v;
        send_cmd(sadc_pkg::SADC_CMD_CONVERT, 400, ok);
        repeat (20) @(posedge clock_i);
        #1 analog_input_i = ~v;
        pop(d);
        check(d, v, "result word");
    endtask : conv

    task automatic wait_drop(input string what);
        repeat (150) @(posedge clock_i);
        #1 check(12'(res_valid_o), 12'h000, what);
    endtask : wait_drop

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_first;
        bit ok;
        analog_input_i = 12'h5a5;
        send_cmd(sadc_pkg::SADC_CMD_CONVERT, 400, ok);
        wait_drop("first result kept");
    endtask : t_first

    task automatic t_convert;
        logic [11:0] vals [4] = '{12'ha5c, 12'hfff, 12'h001, 12'h800};
        foreach (vals[i]) begin
            conv(vals[i]);
        end
        check(12'(power_down_o), 12'h000, "power down after full frame");
    endtask : t_convert

    task automatic t_fill;
        bit          ok;
        int          acc;
        logic [11:0] d;
        acc = 0;
        ok = 1'b1;
        while (ok && acc < 9) begin
            analog_input_i = 12'h100 + 12'(acc);
            send_cmd(sadc_pkg::SADC_CMD_CONVERT, 300, ok);
            if (ok) begin
                acc++;
            end
        end
        check(12'(acc), 12'h008, "frames accepted until full");
        for (int i = 0; i < 8; i++) begin
            pop(d);
            check(d, 12'h100 + 12'(i), "buffered word");
        end
    endtask : t_fill

    task automatic t_sleep_wake;
        bit ok;
        send_cmd(sadc_pkg::SADC_CMD_SLEEP, 400, ok);
        repeat (60) @(posedge clock_i);
        #1 check(12'(power_down_o), 12'h001, "power down after short frame");
        check(12'(ready_o), 12'h000, "ready while powered down");
        send_cmd(sadc_pkg::SADC_CMD_WAKE, 400, ok);
        repeat (45) @(posedge dev_clk);
        #1 check(12'(ready_o), 12'h000, "ready early in wake frame");
        repeat (70) @(posedge dev_clk);
        #1 check(12'(power_down_o), 12'h000, "power down after wake frame");
        check(12'(ready_o), 12'h001, "ready after wake");
        analog_input_i = 12'h777;
        send_cmd(sadc_pkg::SADC_CMD_CONVERT, 400, ok);
        wait_drop("result after wake kept");
        conv(12'h3c7);
    endtask : t_sleep_wake

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        clock_i = 1'b0;
        dev_clk = 1'b0;
        rst_n_i = 1'b0;
        cmd_valid_i = 1'b0;
        cmd_i = 2'b00;
        res_ready_i = 1'b0;
        analog_input_i = 12'h000;
        mismatches = 0;
        check_count = 0;
        cycles = 0;
        repeat (5) @(posedge clock_i);
        #1 rst_n_i = 1'b1;
        t_first();
        t_convert();
        t_fill();
        t_sleep_wake();
        end_sim();
    end

endmodule : test_serial_adc_conversion_interface

`default_nettype wire
